// ---- common/startup_clock_pkg.sv ----
// package: types and constants for the start-up clock sequencer
package startup_clock_pkg;
	// system clock select encodings
	localparam logic [1:0] SCS_PRIMARY = 2'h0;
	localparam logic [1:0] SCS_SECONDARY = 2'h1;
	localparam logic [1:0] SCS_INTERNAL = 2'h2;
	// internal frequency select: zero is the base low rc rate
	localparam logic [2:0] IFS_RESET = 3'h0;
	localparam logic [1:0] SCS_RESET = 2'h0;
	// status flag position inside the oscillator control view
	localparam int FLAG_POS = 3;
	localparam logic [7:0] OSCCTL_RESET = 8'h00;
	// synchroniser stages on each gate's enable, clocked by that gate's own source once the other is idle
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_INTERNAL,
		SRC_PRIMARY
	} clk_src_e;

	typedef struct packed {
		logic [2:0] internal_freq_select;
		logic [1:0] system_clock_select;
	} osc_ctrl_s;

	typedef struct packed {
		logic reset_event;
		logic wake_event;
		logic pm_entry;
		logic sleep_cmd;
	} start_evt_s;
endpackage

// ---- dv/osc_sources.sv ----
// partner model: oscillator sources and start-up timer around the sequencer
`timescale 1ns/1ps
module osc_sources #(
	parameter int OST_CYCLES = 6
) (
	// control clock and timer restart
	input wire logic clock_i,
	input wire logic start_i,
	// raw sources and timer expiry
	output logic lrc_o,
	output logic mosc_o,
	output logic pri_o,
	output logic ost_done_o
);
	int cnt = -1;
	logic done_q = 1'b0;
	// crystal primary only: other sources have no start-up timer
	initial begin
		lrc_o = 1'b0;
		forever #15.1 lrc_o = ~lrc_o;
	end
	initial begin
		mosc_o = 1'b0;
		forever #5.3 mosc_o = ~mosc_o;
	end
	initial begin
		pri_o = 1'b0;
		forever #7.3 pri_o = ~pri_o;
	end
	assign ost_done_o = done_q;
	// one-cycle expiry pulse, restartable in mid-count
	always @(posedge clock_i) begin
		done_q <= (cnt == 0);
		if (start_i) begin
			cnt <= OST_CYCLES;
		end else if (cnt >= 0) begin
			cnt <= cnt - 1;
		end
	end
endmodule

// ---- dv/two_speed_startup_clock_switch_tb.sv ----
// testbench: start-up sequencer against a small state model
`timescale 1ns/1ps
module two_speed_startup_clock_switch_tb;
	import startup_clock_pkg::*;
	logic clock_i = 1'b0, nrst_i = 1'b0, en = 1'b0, pwr = 1'b0, we = 1'b0, start = 1'b0;
	logic lrc, mosc, pri, oscillator_startup_timer, flag, run, slp, cclk;
	logic [7:0] creg;
	start_evt_s evt = '0;
	osc_ctrl_s cin = '0, cout;
	clk_src_e src;
	int error_cnt = 0, comparisons = 0;
	int mstate = 0;
	int cedges = 0;
	always #2 clock_i = ~clock_i;
	always @(posedge cclk) begin
		cedges++;
	end
	osc_sources #(.OST_CYCLES(6)) part (.clock_i(clock_i), .start_i(start), .lrc_o(lrc), .mosc_o(mosc),
		.pri_o(pri), .ost_done_o(oscillator_startup_timer));
	two_speed_startup_clock_switch uut (.clock_i(clock_i), .nrst_i(nrst_i), .internal_low_rc_clock_i(lrc),
		.internal_main_oscillator_i(mosc), .primary_clock_i(pri), .dual_clock_startup_enable_i(en),
		.powerup_timer_done_i(pwr), .oscillator_startup_timer_done_i(oscillator_startup_timer), .evt_i(evt), .ctrl_we_i(we),
		.ctrl_i(cin), .ctrl_o(cout), .primary_clock_active_flag_o(flag), .oscillator_control_reg_o(creg),
		.primary_run_mode_o(run), .sleeping_o(slp), .src_o(src), .core_clk_o(cclk));
	// ==========
	// checks and drivers
	task automatic close_out;
		$display("counts: %0d compared, %0d mismatched", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(logic [7:0] got, logic [7:0] exp, string m);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// model: 0 powerup, 1 interim, 2 primary run, 3 asleep
	function automatic clk_src_e model_src();
		return (mstate == 2) ? SRC_PRIMARY : (mstate == 1) ? SRC_INTERNAL : SRC_NONE;
	endfunction
	task automatic chk_src(string m);
		chk({6'h0, src}, {6'h0, model_src()}, m);
		chk({7'h0, flag}, {7'h0, mstate == 2}, "flag");
		chk({7'h0, creg[FLAG_POS]}, {7'h0, mstate == 2}, "reg flag");
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	// gated core clock: edges seen over a window, long enough for a gate to open
	task automatic chk_clk(bit running, string m);
		int n;
		n = cedges;
		step(40);
		chk({7'h0, cedges != n}, {7'h0, running}, m);
	endtask
	task automatic fire(start_evt_s e);
		@(posedge clock_i);
		evt <= e;
		@(posedge clock_i);
		evt <= '0;
		step(1);
	endtask
	task automatic run_ost;
		int i;
		@(posedge clock_i);
		start <= 1'b1;
		@(posedge clock_i);
		start <= 1'b0;
		for (i = 0; i < 50 && !oscillator_startup_timer; i++) begin
			step(1);
		end
		if (!oscillator_startup_timer) begin
			error_cnt++;
			$display("MISMATCH %0t start-up timer never expired", $time);
			close_out();
		end
		step(2);
		mstate = 2;
	endtask
	// ==========
	// main sequence
	initial begin
		void'($urandom(96359));
		repeat (4) @(posedge clock_i);
		nrst_i <= 1'b1;
		step(2);
		chk(creg, OSCCTL_RESET, "reg after reset");
		chk({3'h0, cout}, 8'h00, "ctrl after reset");
		@(posedge clock_i);
		pwr <= 1'b1;
		step(3);
		chk_src("no interim when disabled");
		run_ost();
		chk_src("primary after timer, disabled");
		chk_clk(1'b1, "core clock from primary");
		$display("test disabled start-up done");
		@(posedge clock_i);
		en <= 1'b1;
		fire('{reset_event: 1'b1, default: 1'b0});
		step(1);
		mstate = 1;
		chk_src("interim after reset");
		chk({3'h0, cout}, 8'h00, "ctrl cleared");
		@(posedge clock_i);
		cin <= '{internal_freq_select: 3'($urandom_range(7, 1)), system_clock_select: SCS_PRIMARY};
		we <= 1'b1;
		@(posedge clock_i);
		we <= 1'b0;
		step(1);
		chk({3'h0, cout}, {3'h0, cin}, "ctrl write");
		chk({5'h0, creg[6:4]}, {5'h0, cin.internal_freq_select}, "reg freq");
		chk_clk(1'b1, "core clock from interim");
		repeat (2) begin
			fire('{sleep_cmd: 1'b1, default: 1'b0});
			chk({7'h0, slp}, 8'h01, "asleep in interim");
			fire('{wake_event: 1'b1, default: 1'b0});
			step(1);
			chk({7'h0, slp}, 8'h00, "awake");
			chk_src("interim after wake");
		end
		run_ost();
		chk_src("switched to primary");
		chk({7'h0, run}, 8'h01, "primary run");
		$display("test two-speed start-up done");
		fire('{pm_entry: 1'b1, default: 1'b0});
		step(1);
		chk_src("pm entry keeps source");
		@(posedge clock_i);
		nrst_i <= 1'b0;
		step(2);
		mstate = 0;
		chk(creg, OSCCTL_RESET, "reg on reset");
		chk({7'h0, run}, 8'h00, "run on reset");
		chk_clk(1'b0, "core clock stopped in reset");
		$display("test power-managed and reset done");
		close_out();
	end
endmodule

// ---- rtl/clk_gate_stage.sv ----
// one glitch-free gate stage: enable resynchronised, then gated on the low phase
`timescale 1ns/1ps
module clk_gate_stage #(
	parameter int STAGES = 2
) (
	// source clock and its reset
	input wire logic src_clk_i,
	input wire logic nrst_i,
	// request to pass this clock, and the other gate's idle status
	input wire logic want_i,
	input wire logic other_off_i,
	// gated clock and its own idle status
	output logic gclk_o,
	output logic off_o
);
	logic [STAGES-1:0] sync;
	logic [STAGES-1:0] next_sync;
	logic en_low;

	always_comb begin
		next_sync = {sync[STAGES-2:0], want_i & other_off_i};
	end

	always_ff @(posedge src_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync <= '0;
		end else begin
			sync <= next_sync;
		end
	end

	// enable changes only while the source is low, so no runt phase escapes
	always_ff @(negedge src_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			en_low <= 1'b0;
		end else begin
			en_low <= sync[STAGES-1];
		end
	end

	assign gclk_o = src_clk_i & en_low;
	assign off_o = ~en_low & ~sync[STAGES-1];
endmodule

// ---- rtl/two_speed_startup_clock_switch.sv ----
// start-up clock sequencer: internal interim clock, then primary after its timer
//
// Behaviour
// - dual-clock start-up only when the enable strap is set; else wait for primary.
// - reset and sleep wake run from internal clock, after power-up delay on power-on.
// - on start-up timer expiry switch to primary and primary run automatically, unless clock select is internal.
// - control register clears on reset, so interim clock is base low rc.
// - other power-managed modes ignore the enable and keep the selected source.
// - clock-select writes and repeated sleeps are honoured during interim running.
// - status flag bit 3 reads set while primary clocks the device.
`timescale 1ns/1ps
module two_speed_startup_clock_switch (
	// control clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// oscillator sources
	input wire logic internal_low_rc_clock_i,
	input wire logic internal_main_oscillator_i,
	input wire logic primary_clock_i,
	// configuration and timers
	input wire logic dual_clock_startup_enable_i,
	input wire logic powerup_timer_done_i,
	input wire logic oscillator_startup_timer_done_i,
	// events from the core
	input wire startup_clock_pkg::start_evt_s evt_i,
	// control register write port
	input wire logic ctrl_we_i,
	input wire startup_clock_pkg::osc_ctrl_s ctrl_i,
	// status
	output startup_clock_pkg::osc_ctrl_s ctrl_o,
	output logic primary_clock_active_flag_o,
	output logic [7:0] oscillator_control_reg_o,
	output logic primary_run_mode_o,
	output logic sleeping_o,
	output startup_clock_pkg::clk_src_e src_o,
	// core clock
	output logic core_clk_o
);
	import startup_clock_pkg::*;

	typedef enum logic [2:0] {
		ST_POWERUP,
		ST_WAIT_PRI,
		ST_INTERIM,
		ST_SLEEP,
		ST_RUN
	} seq_e;

	seq_e state, next_state;
	osc_ctrl_s ctrl, next_ctrl;
	logic two_speed, next_two_speed;
	logic pri_ok, next_pri_ok;
	logic [7:0] ctrl_reg, next_ctrl_reg;
	clk_src_e want, next_want;
	logic run, next_run;
	logic sleep_q, next_sleep_q;
	logic want_int, want_pri, int_off, pri_off, gint, gpri;
	logic interim_clk;

	// ==========================================================
	// sequencer
	always_comb begin
		next_state = state;
		next_ctrl = ctrl;
		next_two_speed = two_speed;
		next_pri_ok = pri_ok;
		if (ctrl_we_i) begin
			next_ctrl = ctrl_i;
		end
		if (oscillator_startup_timer_done_i) begin
			next_pri_ok = 1'b1;
		end
		unique case (state)
			ST_POWERUP: begin
				if (powerup_timer_done_i) begin
					next_state = dual_clock_startup_enable_i ? ST_INTERIM : ST_WAIT_PRI;
				end
			end
			ST_WAIT_PRI: begin
				// an expiry seen while still in power-up must not be lost
				if (pri_ok || oscillator_startup_timer_done_i) begin
					next_state = ST_RUN;
				end
			end
			ST_INTERIM: begin
				if (evt_i.sleep_cmd) begin
					next_state = ST_SLEEP;
				end else if (pri_ok || oscillator_startup_timer_done_i) begin
					next_state = ST_RUN;
				end
			end
			ST_SLEEP: begin
				next_pri_ok = 1'b0;
				if (evt_i.wake_event) begin
					next_two_speed = dual_clock_startup_enable_i;
					next_state = dual_clock_startup_enable_i ? ST_INTERIM : ST_WAIT_PRI;
				end
			end
			ST_RUN: begin
				if (evt_i.sleep_cmd) begin
					next_state = ST_SLEEP;
				end
			end
		endcase
		// power-managed entries keep the selected source, enable ignored
		if (evt_i.pm_entry && state != ST_SLEEP) begin
			next_two_speed = 1'b0;
		end
		if (evt_i.reset_event) begin
			next_state = ST_POWERUP;
			next_ctrl = '{internal_freq_select: IFS_RESET, system_clock_select: SCS_RESET};
			next_pri_ok = 1'b0;
			next_two_speed = 1'b1;
		end
	end

	// source choice and outputs
	always_comb begin
		next_want = SRC_NONE;
		next_run = 1'b0;
		next_sleep_q = (next_state == ST_SLEEP);
		unique case (next_state)
			ST_INTERIM: next_want = SRC_INTERNAL;
			ST_RUN: begin
				next_want = (next_ctrl.system_clock_select == SCS_INTERNAL) ? SRC_INTERNAL : SRC_PRIMARY;
				next_run = (next_want == SRC_PRIMARY);
			end
			default: next_want = SRC_NONE;
		endcase
		next_ctrl_reg = {1'b0, next_ctrl.internal_freq_select, 2'h0, next_ctrl.system_clock_select};
		next_ctrl_reg[FLAG_POS] = (next_want == SRC_PRIMARY);
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= ST_POWERUP;
			ctrl <= '{internal_freq_select: IFS_RESET, system_clock_select: SCS_RESET};
			two_speed <= 1'b1;
			pri_ok <= 1'b0;
			want <= SRC_NONE;
			run <= 1'b0;
			sleep_q <= 1'b0;
			ctrl_reg <= OSCCTL_RESET;
		end else begin
			state <= next_state;
			ctrl <= next_ctrl;
			two_speed <= next_two_speed;
			pri_ok <= next_pri_ok;
			want <= next_want;
			run <= next_run;
			sleep_q <= next_sleep_q;
			ctrl_reg <= next_ctrl_reg;
		end
	end

	assign ctrl_o = ctrl;
	assign oscillator_control_reg_o = ctrl_reg;
	assign primary_clock_active_flag_o = ctrl_reg[FLAG_POS];
	assign primary_run_mode_o = run;
	assign sleeping_o = sleep_q;
	assign src_o = want;

	// ==========================================================
	// clock path; base rc until software raises the frequency field
	// limitation: frequency field changes switch the interim mux directly
	assign interim_clk = (ctrl.internal_freq_select == IFS_RESET) ?
		internal_low_rc_clock_i : internal_main_oscillator_i;
	assign want_int = (want == SRC_INTERNAL);
	assign want_pri = (want == SRC_PRIMARY);

	clk_gate_stage #(.STAGES(SYNC_STAGES)) u_gate_int (
		.src_clk_i(interim_clk),
		.nrst_i(nrst_i),
		.want_i(want_int),
		.other_off_i(pri_off),
		.gclk_o(gint),
		.off_o(int_off)
	);

	clk_gate_stage #(.STAGES(SYNC_STAGES)) u_gate_pri (
		.src_clk_i(primary_clock_i),
		.nrst_i(nrst_i),
		.want_i(want_pri),
		.other_off_i(int_off),
		.gclk_o(gpri),
		.off_o(pri_off)
	);

	// each gate opens only after the other is shut: break before make
	assign core_clk_o = gint | gpri;

	// ==========================================================
	// checks
	a_flag_tracks_src: assert property (@(posedge clock_i) disable iff (!nrst_i)
		primary_clock_active_flag_o |-> state == ST_RUN && ctrl.system_clock_select != SCS_INTERNAL)
		else $error("status flag set outside primary running");
	a_no_interim_off: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(state == ST_POWERUP && powerup_timer_done_i && !evt_i.reset_event && !dual_clock_startup_enable_i)
		|=> state == ST_WAIT_PRI)
		else $error("interim clock used while disabled");
	a_interim_after_por: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(state == ST_POWERUP && powerup_timer_done_i && !evt_i.reset_event && dual_clock_startup_enable_i)
		|=> src_o == SRC_INTERNAL)
		else $error("no interim clock after power-up delay");
	a_switch_on_ost: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(state == ST_INTERIM && oscillator_startup_timer_done_i && !evt_i.sleep_cmd && !evt_i.reset_event
		&& !ctrl_we_i && ctrl.system_clock_select != SCS_INTERNAL) |=> primary_run_mode_o)
		else $error("no primary run after timer expiry");
	a_reset_clears: assert property (@(posedge clock_i) disable iff (!nrst_i)
		evt_i.reset_event |=> ctrl.internal_freq_select == IFS_RESET && state == ST_POWERUP)
		else $error("control not cleared by reset");
	a_sleep_honoured: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(state == ST_INTERIM && evt_i.sleep_cmd && !evt_i.reset_event) |=> sleeping_o)
		else $error("sleep ignored during interim");
	a_gates_exclusive: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!(!int_off && !pri_off))
		else $error("both clock gates open");
	a_pm_no_twospeed: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(evt_i.pm_entry && !evt_i.reset_event && state != ST_SLEEP) |=> !two_speed)
		else $error("power-managed entry kept two-speed mode");

	c_interim: cover property (@(posedge clock_i) disable iff (!nrst_i) state == ST_INTERIM ##1 state == ST_RUN);
	c_sleep_wake: cover property (@(posedge clock_i) disable iff (!nrst_i) state == ST_SLEEP ##1 state == ST_INTERIM);
	c_no_enable: cover property (@(posedge clock_i) disable iff (!nrst_i) state == ST_WAIT_PRI ##1 state == ST_RUN);
endmodule
